// ---- rtl/spc_defs.svh ----
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// register byte addresses
`define SPC_ADDR_W 8
`define SPC_ADDR_CTRL 8'h00
`define SPC_ADDR_MIN_DEEP 8'h04
`define SPC_ADDR_WAKE_ALLOW 8'h08
`define SPC_ADDR_STATUS 8'h0c
`define SPC_ADDR_INTERVAL 8'h10
`define SPC_ADDR_DEEP_COUNT 8'h14

// control fields
`define SPC_CTRL_DEEP_EN_BIT 0
`define SPC_CTRL_SPEED_LSB 1
`define SPC_CTRL_SPEED_MSB 2
`define SPC_CTRL_RESET 3'h1

// status fields
`define SPC_STAT_STATE_LSB 0
`define SPC_STAT_STATE_MSB 2
`define SPC_STAT_USB_BIT 4
`define SPC_STAT_EXT_BIT 5

// times in milliseconds
`define SPC_MIN_DEEP_RESET 16'h0064
`define SPC_WAKE_ALLOW_RESET 16'h0014
`define SPC_CLK_REDUCE_MIN_MS 16'h0014

// slow always-on clock, 32 kHz
`define SPC_SLOW_CLK_HZ 32000
`define SPC_MS_PER_S 1000
`define SPC_SLOW_TICKS_PER_MS (`SPC_SLOW_CLK_HZ / `SPC_MS_PER_S)

`endif

// ---- rtl/spc_pkg.sv ----
package spc_pkg;

  // shallow-sleep main bus clock choices: 60.0, 45.0, 18.432, 9.216 MHz
  typedef enum logic [1:0] {
    SPC_MCK_60_0,
    SPC_MCK_45_0,
    SPC_MCK_18_432,
    SPC_MCK_9_216
  } spc_speed_e;

  typedef enum logic [2:0] {
    SPC_RUN,
    SPC_SHALLOW,
    SPC_LOWPWR,
    SPC_TEARDOWN,
    SPC_REINIT,
    SPC_DEEP,
    SPC_SETUP,
    SPC_POSTWAKE
  } spc_state_e;

endpackage

// ---- rtl/spc_wake_timer.sv ----
`timescale 1ns/10ps
`include "spc_defs.svh"

module spc_wake_timer #(
  parameter int TW = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // always-on slow clock pin
  input wire logic slow_clk,
  // control
  input wire logic load,
  input wire logic [TW-1:0] load_ms,
  // status
  output logic done
);

  localparam logic [5:0] TICKS_PER_MS = 6'(`SPC_SLOW_TICKS_PER_MS);

  logic slow_meta;
  logic slow_sync;
  logic slow_prev;
  logic [5:0] pre;
  logic [TW-1:0] count;

  wire slow_rise = slow_sync & ~slow_prev;
  wire ms_tick = slow_rise && (pre == TICKS_PER_MS - 6'h01);

  // slow_meta is read only by slow_sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_prev <= 1'b0;
    end else begin
      slow_meta <= slow_clk;
      slow_sync <= slow_meta;
      slow_prev <= slow_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 6'h00;
      count <= '0;
      done <= 1'b1;
    end else if (load) begin
      pre <= 6'h00;
      count <= load_ms;
      done <= 1'b0;
    end else if (!done) begin
      if (count == '0) begin
        done <= 1'b1;
      end else if (ms_tick) begin
        pre <= 6'h00;
        count <= count - TW'(1);
      end else if (slow_rise) begin
        pre <= pre + 6'h01;
      end
    end
  end

endmodule // spc_wake_timer

// ---- rtl/spc_sleep_ctrl.sv ----
// Overview of operation
// - all threads idle enters shallow sleep
// - shallow keeps power, stops cpu clock
// - shallow exits once any thread ready
// - clocks unchanged unless software picks speed
// - bus clock 60 default, four speeds
// - under 20 ms keep default bus clock
// - deep cuts power and master clocks
// - deep enable resets on; off means shallow
// - sleep length is soonest timed wake
// - interval below minimum deep means shallow
// - spare wake allowance spent in shallow
// - usb attached forbids deep sleep
// - external supply gives slow-clock low-power mode
// - deep needs at least one timed sleeper
// - teardown failure reinitialises, then shallow
// - on approval arm timer, cut power
// - after wake reinit drivers, shallow, resume
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "spc_defs.svh"

module spc_sleep_ctrl #(
  parameter int NT = 4,
  parameter int TW = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // scheduler thread status
  input wire logic [NT-1:0] thread_timed,
  input wire logic [NT-1:0] thread_blocked,
  input wire logic [NT*TW-1:0] thread_wake_ms,
  // board pins
  input wire logic usb_attached,
  input wire logic external_supply_input,
  input wire logic slow_clk,
  // driver tear-down and set-up
  output logic teardown_req,
  input wire logic teardown_done,
  input wire logic teardown_ok,
  output logic setup_req,
  input wire logic setup_done,
  // power and clock controls
  output logic cpu_pwr_en,
  output logic cpu_clk_en,
  output logic main_bus_clock_en,
  output logic [1:0] main_bus_clock_sel,
  output logic main_bus_clock_slow,
  output logic periph_clk_en,
  output logic ram_main_pwr_en,
  output logic ram_active,
  output logic flash_pwr_en,
  output logic radio_pwr_en,
  output logic board_main_pwr_en,
  output logic main_pwr_en
);

  spc_pkg::spc_state_e state;
  spc_pkg::spc_state_e next_state;

  logic [2:0] ctrl;
  logic [TW-1:0] min_deep;
  logic [TW-1:0] wake_allow;
  logic [TW-1:0] interval;
  logic [31:0] deep_count;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic timer_done;

  // board pins through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= {external_supply_input, usb_attached};
      pin_sync <= pin_meta;
    end
  end

  wire usb_on = pin_sync[0];
  wire ext_on = pin_sync[1];
  wire deep_en = ctrl[`SPC_CTRL_DEEP_EN_BIT];
  wire [1:0] speed = ctrl[`SPC_CTRL_SPEED_MSB:`SPC_CTRL_SPEED_LSB];

  // soonest timed wake among sleepers
  wire [TW-1:0] cand [NT:0];
  assign cand[0] = '1;
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_min
      wire [TW-1:0] w = thread_wake_ms[gi*TW +: TW];
      assign cand[gi+1] = (thread_timed[gi] && w < cand[gi]) ? w : cand[gi];
    end
  endgenerate

  wire all_idle = &(thread_timed | thread_blocked);
  wire any_timed = |thread_timed;
  wire [TW-1:0] soonest = cand[NT];
  wire deep_ok = deep_en && any_timed && !usb_on && soonest >= min_deep;
  wire [TW-1:0] deep_ms = (interval > wake_allow) ? interval - wake_allow : '0;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      spc_pkg::SPC_RUN: begin
        if (all_idle && deep_ok && ext_on) begin
          next_state = spc_pkg::SPC_LOWPWR;
        end else if (all_idle && deep_ok) begin
          next_state = spc_pkg::SPC_TEARDOWN;
        end else if (all_idle) begin
          next_state = spc_pkg::SPC_SHALLOW;
        end
      end
      spc_pkg::SPC_SHALLOW, spc_pkg::SPC_LOWPWR: begin
        if (!all_idle) begin
          next_state = spc_pkg::SPC_RUN;
        end
      end
      spc_pkg::SPC_TEARDOWN: begin
        if (teardown_done && teardown_ok) begin
          next_state = spc_pkg::SPC_DEEP;
        end else if (teardown_done) begin
          next_state = spc_pkg::SPC_REINIT;
        end
      end
      spc_pkg::SPC_REINIT: begin
        if (setup_done) begin
          next_state = spc_pkg::SPC_SHALLOW;
        end
      end
      spc_pkg::SPC_DEEP: begin
        if (timer_done) begin
          next_state = spc_pkg::SPC_SETUP;
        end
      end
      spc_pkg::SPC_SETUP: begin
        if (setup_done) begin
          next_state = spc_pkg::SPC_POSTWAKE;
        end
      end
      spc_pkg::SPC_POSTWAKE: begin
        if (timer_done) begin
          next_state = spc_pkg::SPC_RUN;
        end
      end
      default: next_state = spc_pkg::SPC_RUN;
    endcase
  end

  // timer: armed with sleep minus allowance, then with the allowance
  wire arm_deep = state == spc_pkg::SPC_TEARDOWN && next_state == spc_pkg::SPC_DEEP;
  wire arm_wake = state == spc_pkg::SPC_DEEP && next_state == spc_pkg::SPC_SETUP;
  wire timer_load = arm_deep | arm_wake;
  wire [TW-1:0] timer_ms = arm_deep ? deep_ms : wake_allow;

  spc_wake_timer #(
    .TW(TW)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .slow_clk(slow_clk),
    .load(timer_load),
    .load_ms(timer_ms),
    .done(timer_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= spc_pkg::SPC_RUN;
      interval <= '0;
      deep_count <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (state == spc_pkg::SPC_RUN && all_idle) begin
        interval <= any_timed ? soonest : '1;
      end
      if (arm_deep) begin
        deep_count <= deep_count + 32'h0000_0001;
      end
    end
  end

  // output decode of the coming state
  wire n_active = next_state == spc_pkg::SPC_RUN || next_state == spc_pkg::SPC_TEARDOWN ||
                  next_state == spc_pkg::SPC_REINIT || next_state == spc_pkg::SPC_SETUP;
  wire n_deep = next_state == spc_pkg::SPC_DEEP;
  wire n_low = next_state == spc_pkg::SPC_LOWPWR;
  wire n_shallow = next_state == spc_pkg::SPC_SHALLOW || next_state == spc_pkg::SPC_POSTWAKE;
  // slower clock only when chosen and the sleep is long enough
  wire n_reduce = n_shallow && speed != 2'(spc_pkg::SPC_MCK_60_0) &&
                  next_state == spc_pkg::SPC_SHALLOW &&
                  (state == spc_pkg::SPC_RUN ? soonest : interval) >= `SPC_CLK_REDUCE_MIN_MS &&
                  (state == spc_pkg::SPC_RUN ? any_timed : interval != '1);
  wire [1:0] next_sel = n_reduce ? speed : 2'(spc_pkg::SPC_MCK_60_0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_pwr_en <= 1'b1;
      cpu_clk_en <= 1'b1;
      main_bus_clock_en <= 1'b1;
      main_bus_clock_sel <= 2'h0;
      main_bus_clock_slow <= 1'b0;
      periph_clk_en <= 1'b1;
      ram_main_pwr_en <= 1'b1;
      ram_active <= 1'b1;
      flash_pwr_en <= 1'b1;
      radio_pwr_en <= 1'b1;
      board_main_pwr_en <= 1'b1;
      main_pwr_en <= 1'b1;
      teardown_req <= 1'b0;
      setup_req <= 1'b0;
    end else begin
      cpu_clk_en <= n_active;
      ram_active <= n_active;
      periph_clk_en <= !n_deep && !n_low;
      main_bus_clock_en <= !n_deep;
      main_bus_clock_slow <= n_low;
      main_bus_clock_sel <= next_sel;
      cpu_pwr_en <= !n_deep;
      ram_main_pwr_en <= !n_deep;
      flash_pwr_en <= !n_deep;
      radio_pwr_en <= !n_deep;
      board_main_pwr_en <= !n_deep;
      main_pwr_en <= !n_deep;
      teardown_req <= next_state == spc_pkg::SPC_TEARDOWN;
      setup_req <= next_state == spc_pkg::SPC_REINIT ||
                   next_state == spc_pkg::SPC_SETUP;
    end
  end

  // apb slave, one wait state is never needed: answer in access phase
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire hit_ctrl = paddr == `SPC_ADDR_CTRL;
  wire hit_min = paddr == `SPC_ADDR_MIN_DEEP;
  wire hit_allow = paddr == `SPC_ADDR_WAKE_ALLOW;
  wire hit_stat = paddr == `SPC_ADDR_STATUS;
  wire hit_int = paddr == `SPC_ADDR_INTERVAL;
  wire hit_cnt = paddr == `SPC_ADDR_DEEP_COUNT;
  wire hit_any = hit_ctrl | hit_min | hit_allow | hit_stat | hit_int | hit_cnt;

  wire [2:0] state_code = state;
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SPC_STAT_STATE_MSB:`SPC_STAT_STATE_LSB] = state_code;
    status_word[`SPC_STAT_USB_BIT] = usb_on;
    status_word[`SPC_STAT_EXT_BIT] = ext_on;
  end

  wire [31:0] rd_value =
      hit_ctrl ? {29'h0, ctrl} :
      hit_min ? {{(32-TW){1'b0}}, min_deep} :
      hit_allow ? {{(32-TW){1'b0}}, wake_allow} :
      hit_stat ? status_word :
      hit_int ? {{(32-TW){1'b0}}, interval} :
      hit_cnt ? deep_count : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      prdata <= (setup_ph && !pwrite) ? rd_value : 32'h0000_0000;
      pslverr <= setup_ph & ~hit_any;
    end
  end

  // unmapped writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SPC_CTRL_RESET;
      min_deep <= TW'(`SPC_MIN_DEEP_RESET);
      wake_allow <= TW'(`SPC_WAKE_ALLOW_RESET);
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl <= pwdata[2:0];
      end else if (hit_min) begin
        min_deep <= pwdata[TW-1:0];
      end else if (hit_allow) begin
        wake_allow <= pwdata[TW-1:0];
      end
    end
  end

endmodule // spc_sleep_ctrl

// ---- dv/spc_sleep_ctrl_checker.sv ----
`timescale 1ns/10ps
module spc_sleep_ctrl_checker #(
  parameter int NT = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // threads and pins
  input wire logic [NT-1:0] thread_timed,
  input wire logic [NT-1:0] thread_blocked,
  input wire logic usb_attached,
  // drivers
  input wire logic teardown_req,
  input wire logic teardown_done,
  input wire logic teardown_ok,
  input wire logic setup_req,
  input wire logic setup_done,
  // controls
  input wire logic cpu_clk_en,
  input wire logic [1:0] main_bus_clock_sel,
  input wire logic main_bus_clock_slow,
  input wire logic periph_clk_en,
  input wire logic radio_pwr_en,
  input wire logic main_pwr_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // post-wake ignores threads, so wake checks must skip it
  logic post;
  wire idle = &(thread_timed | thread_blocked);
  wire run = cpu_clk_en && !teardown_req && !setup_req && main_pwr_en;
  wire next_post = !main_pwr_en || (post && !run);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) post <= 1'b0;
    else post <= next_post;
  end
  property p_idle_sleeps;
    run && idle |=> !cpu_clk_en || teardown_req;
  endproperty
  a_idle_sleeps: assert property (p_idle_sleeps) else $error("idle run kept cpu clock");
  property p_ready_wakes;
    !cpu_clk_en && main_pwr_en && !post && !idle |=> cpu_clk_en;
  endproperty
  a_ready_wakes: assert property (p_ready_wakes) else $error("ready thread not woken");
  property p_deep_off;
    !main_pwr_en |-> !cpu_clk_en && !periph_clk_en && !radio_pwr_en;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("deep sleep left power on");
  property p_usb_no_deep;
    usb_attached [*5] |-> !$rose(teardown_req) && !$rose(main_bus_clock_slow);
  endproperty
  a_usb_no_deep: assert property (p_usb_no_deep) else $error("deep entry on usb");
  property p_lowpwr;
    main_bus_clock_slow |-> !cpu_clk_en && !periph_clk_en && radio_pwr_en && main_pwr_en;
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("low-power mode outputs wrong");
  property p_veto;
    teardown_req && teardown_done && !teardown_ok |=> !teardown_req && main_pwr_en;
  endproperty
  a_veto: assert property (p_veto) else $error("veto did not keep power");
  property p_approve;
    teardown_req && teardown_done && teardown_ok |=> !main_pwr_en && !teardown_req;
  endproperty
  a_approve: assert property (p_approve) else $error("approval did not cut power");
  property p_restore;
    post && setup_req && setup_done |=> !setup_req && !cpu_clk_en && main_bus_clock_sel == 2'h0;
  endproperty
  a_restore: assert property (p_restore) else $error("set-up not followed by shallow");
endmodule // spc_sleep_ctrl_checker

bind spc_sleep_ctrl spc_sleep_ctrl_checker #(.NT(NT)) u_chk (.pclk, .presetn, .thread_timed,
  .thread_blocked, .usb_attached, .teardown_req, .teardown_done, .teardown_ok, .setup_req,
  .setup_done, .cpu_clk_en, .main_bus_clock_sel, .main_bus_clock_slow, .periph_clk_en,
  .radio_pwr_en, .main_pwr_en);

// ---- dv/spc_driver_model.sv ----
`timescale 1ns/10ps
module spc_driver_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the bench
  input wire logic fail,
  input wire logic [3:0] delay,
  // handshake
  input wire logic teardown_req,
  input wire logic setup_req,
  output logic teardown_done,
  output logic teardown_ok,
  output logic setup_done
);
  logic [3:0] cnt;
  wire hit = (cnt == delay);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      teardown_done <= 1'b0;
      teardown_ok <= 1'b0;
      setup_done <= 1'b0;
    end else begin
      cnt <= ((teardown_req || setup_req) && !hit) ? cnt + 4'h1 : 4'h0;
      teardown_done <= teardown_req && hit && !teardown_done;
      // ok only means something with done, so it wanders otherwise
      teardown_ok <= (teardown_req && hit) ? !fail : !teardown_ok;
      setup_done <= setup_req && hit && !setup_done;
    end
  end
endmodule // spc_driver_model

// ---- dv/spc_sleep_ctrl_tb.sv ----
`timescale 1ns/10ps
module spc_sleep_ctrl_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, fail = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, usb_attached = 0, external_supply_input = 0, slow_clk = 0;
  logic [3:0] thread_timed = 4'h0, thread_blocked = 4'h0, delay = 4'h1;
  logic [63:0] thread_wake_ms = 64'h0;
  logic teardown_req, teardown_done, teardown_ok, setup_req, setup_done, cpu_pwr_en;
  logic cpu_clk_en, main_bus_clock_en, main_bus_clock_slow, periph_clk_en, ram_main_pwr_en;
  logic ram_active, flash_pwr_en, radio_pwr_en, board_main_pwr_en, main_pwr_en;
  logic [1:0] main_bus_clock_sel, sp;
  logic [2:0] slow_div = 3'h0;
  int n_errors = 0, cmp_count = 0, seed = 32, n, wk;
  wire [7:0] ctl = {main_pwr_en, cpu_clk_en, ram_active, periph_clk_en,
    main_bus_clock_slow, teardown_req, main_bus_clock_sel};
  wire [5:0] pwr = {cpu_pwr_en, main_bus_clock_en, ram_main_pwr_en, flash_pwr_en,
    radio_pwr_en, board_main_pwr_en};
  always #4 pclk = ~pclk;
  // slow clock sped up so one ms is 256 pclk cycles
  always @(posedge pclk) begin
    slow_div <= slow_div + 3'h1;
    slow_clk <= slow_div[2];
  end
  spc_sleep_ctrl #(.NT(4), .TW(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .thread_timed, .thread_blocked, .thread_wake_ms,
    .usb_attached, .external_supply_input, .slow_clk, .teardown_req, .teardown_done,
    .teardown_ok, .setup_req, .setup_done, .cpu_pwr_en, .cpu_clk_en, .main_bus_clock_en,
    .main_bus_clock_sel, .main_bus_clock_slow, .periph_clk_en, .ram_main_pwr_en, .ram_active,
    .flash_pwr_en, .radio_pwr_en, .board_main_pwr_en, .main_pwr_en);
  spc_driver_model drv (.pclk, .presetn, .fail, .delay, .teardown_req, .setup_req,
    .teardown_done, .teardown_ok, .setup_done);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state limit here: only the watchdog ends a stuck transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task nap(input logic [3:0] t, input logic [3:0] b, input logic [63:0] w);
    thread_timed <= 4'h0;
    thread_blocked <= 4'h0;
    repeat (3) @(posedge pclk);
    thread_wake_ms <= w;
    thread_timed <= t;
    thread_blocked <= b;
    repeat (3) @(posedge pclk);
  endtask
  task automatic waitc(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask
  function automatic logic [1:0] exp_sel(input logic [1:0] s, input int ms);
    return (ms >= 20) ? s : 2'h0;
  endfunction
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h00, 32'h1);
    rdchk(8'h04, 32'h64);
    rdchk(8'h08, 32'h14);
    apb(1'b1, 8'h0c, 32'h5);
    rdchk(8'h0c, 32'h0);
    rdchk(8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h08, 32'h2);
    nap(4'h0, 4'hf, 64'h0);
    chk(ctl, 8'h90);
    chk(pwr, 6'h3f);
    thread_blocked <= 4'h7;
    repeat (2) @(posedge pclk);
    chk(ctl, 8'hf0);
    for (int i = 0; i < 8; i++) begin
      sp = (i < 4) ? 2'(i) : 2'($random(seed));
      wk = (i < 4) ? 20 + i : (i == 4) ? 19 : 10 + ($random(seed) & 31);
      apb(1'b1, 8'h00, {29'h0, sp, 1'b0});
      nap(4'h1, 4'he, {48'h0, 16'(wk)});
      chk(ctl, {6'h24, exp_sel(sp, wk)});
    end
    apb(1'b1, 8'h00, 32'h1);
    usb_attached <= 1'b1;
    nap(4'h1, 4'he, 64'h6);
    chk(ctl, 8'h90);
    rdchk(8'h0c, 32'h11);
    usb_attached <= 1'b0;
    external_supply_input <= 1'b1;
    nap(4'h1, 4'he, 64'h6);
    chk(ctl, 8'h88);
    chk(pwr, 6'h3f);
    rdchk(8'h0c, 32'h22);
    external_supply_input <= 1'b0;
    nap(4'hf, 4'h0, 64'h0008_0007_0003_0009);
    chk(ctl, 8'h90);
    rdchk(8'h10, 32'h3);
    fail <= 1'b1;
    nap(4'h1, 4'he, 64'h6);
    waitc(setup_req, 1'b1, 50);
    waitc(setup_req, 1'b0, 50);
    @(posedge pclk);
    chk(ctl, 8'h90);
    fail <= 1'b0;
    delay <= 4'h9;
    nap(4'h1, 4'he, 64'h6);
    waitc(main_pwr_en, 1'b0, 60);
    chk(ctl, 8'h00);
    chk(pwr, 6'h00);
    waitc(setup_req, 1'b1, 1500);
    chk({31'h0, n >= 1000 && n <= 1050}, 32'h1);
    waitc(cpu_clk_en, 1'b0, 100);
    chk(ctl, 8'h90);
    thread_timed <= 4'h0;
    waitc(cpu_clk_en, 1'b1, 700);
    chk({31'h0, n >= 460 && n <= 530}, 32'h1);
    rdchk(8'h14, 32'h1);
    end_of_test;
  end
endmodule // spc_sleep_ctrl_tb
